// >>> cgs_top.sv
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
// Behaviour
// - Oscillator enable counts eight times startup value slow ticks, then flags stable.
// - Count main clock cycles over sixteen slow cycles; flag measure ready.
// - Divider zero keeps PLL A divider off; reset value zero.
// - Multiplier 0..2047; zero disables PLL, else output is input times mul+1.
// - After PLL config write wait lock delay slow cycles then set locked.
// - Changing multiplier or divider clears locked until relock.
// - Source select picks prescaler input; main clock after reset.
// - Master clock is selected source over prescaler; processor clock equals it.
// - Source or prescaler change drops master ready until new clock settles.
// - Reprogramming active PLL forces slow clock, ready low until relock.
// - Three programmable outputs with enable, disable, state; off after reset.
// - Programmable source: main, slow, PLL A, USB PLL; slow at reset.
// - Programmable clock divides by 1,2,4,8,16,32 or 64.
// - Enabled programmable clock sets its ready flag once valid.
// - Fifteen peripheral clocks gated by enable and disable, state readable.
// - A non-zero prescaler in the written word makes a switch count 64 slow cycles instead of 4.
// - Write protect blocks listed configuration register writes.
// - Protected write sets violation flag and source; read clears flag.
// - Programmable prescaler value n divides by two to the n.
module cgs_top
	import cgs_pkg::*;
(
	input  wire logic        hclk,      // Bus clock, 100 MHz.
	input  wire logic        hresetn,   // Asynchronous reset, low.
	input  wire logic        hsel,      // Slave select.
	input  wire logic [31:0] haddr,     // Byte address.
	input  wire logic [1:0]  htrans,    // Transfer type.
	input  wire logic        hwrite,    // Write strobe.
	input  wire logic [2:0]  hsize,     // Transfer size.
	input  wire logic [31:0] hwdata,    // Write data.
	input  wire logic        hready,    // Bus ready in.
	input  wire logic        main_tick, // Main clock edge enable.
	output logic [31:0]      hrdata,    // Read data.
	output logic             hreadyout, // Slave ready.
	output logic             hresp,     // Always OKAY.
	output logic [1:0]       mclk_src,  // Active master source.
	output logic [2:0]       mclk_div,  // Active master prescaler.
	output logic [2:0]       pck_en,    // Programmable clock gates.
	output logic [31:0]      per_en,    // Peripheral clock gates.
	output logic             pll_a_on,  // PLL A powered.
	output logic             irq        // Controller interrupt.
);
`include "cgs_defines.svh"
	typedef struct packed {
		logic        dph;
		logic        dwr;
		logic [11:0] dadr;
		logic [31:0] rdata;
		logic [31:0] osc;
		logic [31:0] pll;
		logic [31:0] mck;
		logic [31:0] pck0;
		logic [31:0] pck1;
		logic [31:0] pck2;
		logic [2:0]  pck_on;
		logic [2:0]  pck_rdy;
		logic [31:0] per;
		logic [31:0] imr;
		logic [31:0] fsm;
		logic [31:0] fsp;
		logic [31:0] ucfg;
		logic        write_protect_enable;
		logic        protect_violation_flag;
		logic [7:0]  wpsrc;
		logic        osc_rdy;
		logic        lock;
		logic        mrdy;
		logic        frdy;
		logic [15:0] fcnt;
		logic [15:0] fval;
		logic [4:0]  fwin;
		logic [15:0] sdiv;
		logic        stick;
		cgs_sw_e     sw;
		logic [7:0]  swcnt;
		logic [1:0]  src;
		logic [2:0]  div;
		logic        irq;
		logic        pll_on;
	} cgs_state_s;
	cgs_state_s s_reg;
	cgs_state_s s_next;
	logic       osc_done;
	logic       lock_done;
	logic       osc_load;
	logic       pll_load;
	logic [15:0] osc_val;
	logic [31:0] sr_val;
	logic       wr;
	logic       mck_wr;

	// Registers that write protection covers.
	function automatic logic is_protected(input logic [11:0] a);
		case (a)
			`CGS_SYS_CLK_ENABLE, `CGS_SYS_CLK_DISABLE,
			`CGS_PER_CLK_ENABLE, `CGS_PER_CLK_DISABLE,
			`CGS_USB_PLL_CONFIG, `CGS_OSC_CONFIG,
			`CGS_PLL_A_CONFIG, `CGS_PROG_CLK0, `CGS_PROG_CLK1,
			`CGS_PROG_CLK2, `CGS_FAST_MODE,
			`CGS_FAST_POLARITY: is_protected = 1'b1;
			default: is_protected = 1'b0;
		endcase
	endfunction

	// Divider and multiplier fields of a PLL A word, which gate lock.
	function automatic logic [18:0] pll_key(input logic [31:0] w);
		pll_key = {w[26:16], w[7:0]};
	endfunction

	assign wr = s_reg.dph && s_reg.dwr;
	assign mck_wr = wr && s_reg.dadr == `CGS_MCLK_CONFIG;
	assign osc_val = 16'(s_next.osc[15:8]) * 16'(`CGS_OSC_MULT);
	assign osc_load = wr && s_reg.dadr == `CGS_OSC_CONFIG && !s_reg.write_protect_enable
		&& hwdata[`CGS_OSC_EN_BIT] && !s_reg.osc[`CGS_OSC_EN_BIT];
	assign pll_load = wr && s_reg.dadr == `CGS_PLL_A_CONFIG && !s_reg.write_protect_enable;

	// Start-up count of eight slow cycles per startup unit.
	cgs_counter u_osc (
		.hclk    (hclk),
		.hresetn (hresetn),
		.load    (osc_load),
		.value   (osc_val),
		.tick    (s_reg.stick),
		.done    (osc_done)
	);

	// Lock delay counted in slow cycles after each PLL A write.
	cgs_counter u_lock (
		.hclk    (hclk),
		.hresetn (hresetn),
		.load    (pll_load),
		.value   ({10'h000, hwdata[13:8]}),
		.tick    (s_reg.stick),
		.done    (lock_done)
	);

	always_comb begin
		sr_val = 32'h0000_0000;
		sr_val[`CGS_ST_OSC_BIT]  = s_reg.osc_rdy;
		sr_val[`CGS_ST_LOCK_BIT] = s_reg.lock;
		sr_val[`CGS_ST_MRDY_BIT] = s_reg.mrdy;
		sr_val[10:8]             = s_reg.pck_rdy;
	end

	// Whole next state: bus, clock sequencing and status flags.
	always_comb begin
		s_next = s_reg;
		// Slow clock enable derived from the bus clock.
		s_next.stick = 1'b0;
		if (s_reg.sdiv == 16'h0000) begin
			s_next.sdiv  = `CGS_SLOW_DIV;
			s_next.stick = 1'b1;
		end else begin
			s_next.sdiv = s_reg.sdiv - 16'h0001;
		end
		// Address phase capture; zero wait states.
		s_next.dph = hsel && hready && htrans[1];
		s_next.dwr = hwrite;
		s_next.dadr = haddr[11:0];
		s_next.rdata = 32'h0000_0000;
		if (hsel && hready && htrans[1] && !hwrite) begin
			case (haddr[11:0])
				`CGS_SYS_CLK_STATE: s_next.rdata = {21'h0,
					s_reg.pck_on, 8'h01};
				`CGS_PER_CLK_STATE: s_next.rdata = s_reg.per;
				`CGS_USB_PLL_CONFIG: s_next.rdata = s_reg.ucfg;
				`CGS_OSC_CONFIG:    s_next.rdata = s_reg.osc;
				`CGS_FREQ_MEASURE:  s_next.rdata = {15'h0, s_reg.frdy,
					s_reg.fval};
				`CGS_PLL_A_CONFIG:  s_next.rdata = s_reg.pll;
				`CGS_MCLK_CONFIG:   s_next.rdata = s_reg.mck;
				`CGS_PROG_CLK0:     s_next.rdata = s_reg.pck0;
				`CGS_PROG_CLK1:     s_next.rdata = s_reg.pck1;
				`CGS_PROG_CLK2:     s_next.rdata = s_reg.pck2;
				`CGS_CLK_STATUS:    s_next.rdata = sr_val;
				`CGS_INT_MASK:      s_next.rdata = s_reg.imr;
				`CGS_FAST_MODE:     s_next.rdata = s_reg.fsm;
				`CGS_FAST_POLARITY: s_next.rdata = s_reg.fsp;
				`CGS_WP_MODE:       s_next.rdata = {31'h0, s_reg.write_protect_enable};
				`CGS_WP_STATE: begin
					s_next.rdata = {16'h0, s_reg.wpsrc, 7'h0, s_reg.protect_violation_flag};
					s_next.protect_violation_flag  = 1'b0;
				end
				default: s_next.rdata = 32'h0000_0000;
			endcase
		end
		// Data phase write.
		if (wr && s_reg.write_protect_enable && is_protected(s_reg.dadr)) begin
			s_next.protect_violation_flag  = 1'b1;
			s_next.wpsrc = s_reg.dadr[9:2];
		end else if (wr) begin
			case (s_reg.dadr)
				`CGS_SYS_CLK_ENABLE:  s_next.pck_on = s_reg.pck_on
					| hwdata[10:8];
				`CGS_SYS_CLK_DISABLE: s_next.pck_on = s_reg.pck_on
					& ~hwdata[10:8];
				`CGS_PER_CLK_ENABLE:  s_next.per = s_reg.per
					| (hwdata & `CGS_PER_MASK);
				`CGS_PER_CLK_DISABLE: s_next.per = s_reg.per & ~hwdata;
				`CGS_USB_PLL_CONFIG:  s_next.ucfg = hwdata;
				`CGS_OSC_CONFIG: begin
					s_next.osc = hwdata;
					if (!hwdata[`CGS_OSC_EN_BIT]) begin
						s_next.osc_rdy = 1'b0;
					end
				end
				`CGS_PLL_A_CONFIG: begin
					s_next.pll = hwdata;
					if (pll_key(hwdata) != pll_key(s_reg.pll)) begin
						s_next.lock = 1'b0;
					end
				end
				`CGS_MCLK_CONFIG: s_next.mck = {25'h0, hwdata[6:4], 2'b00,
					hwdata[1:0]};
				`CGS_PROG_CLK0: s_next.pck0 = {25'h0, hwdata[6:0]};
				`CGS_PROG_CLK1: s_next.pck1 = {25'h0, hwdata[6:0]};
				`CGS_PROG_CLK2: s_next.pck2 = {25'h0, hwdata[6:0]};
				`CGS_INT_ENABLE:  s_next.imr = s_reg.imr | hwdata;
				`CGS_INT_DISABLE: s_next.imr = s_reg.imr & ~hwdata;
				`CGS_FAST_MODE:     s_next.fsm = hwdata;
				`CGS_FAST_POLARITY: s_next.fsp = hwdata;
				`CGS_WP_MODE: s_next.write_protect_enable = hwdata[0];
				default: s_next.write_protect_enable = s_reg.write_protect_enable;
			endcase
		end
		// Oscillator stable after the start-up count.
		// A disable in this cycle must not be undone by an old finished count.
		if (osc_done && s_reg.osc[`CGS_OSC_EN_BIT]
			&& s_next.osc[`CGS_OSC_EN_BIT]) begin
			s_next.osc_rdy = 1'b1;
		end
		// PLL lock needs non-zero divider and multiplier; done is stale
		// in the cycle in which a write reloads the lock count.
		if (lock_done && !pll_load && s_reg.pll[7:0] != 8'h00
			&& s_reg.pll[26:16] != 11'h000) begin
			s_next.lock = 1'b1;
		end
		// Frequency measure over sixteen slow ticks.
		if (s_reg.stick) begin
			if (s_reg.fwin == 5'(`CGS_FREQ_WINDOW - 1)) begin
				s_next.fwin = 5'h00;
				s_next.fval = s_reg.fcnt;
				s_next.fcnt = 16'h0000;
				s_next.frdy = 1'b1;
			end else begin
				s_next.fwin = s_reg.fwin + 5'h01;
			end
		end
		if (main_tick && !(s_reg.stick
			&& s_reg.fwin == 5'(`CGS_FREQ_WINDOW - 1))) begin
			s_next.fcnt = s_next.fcnt + 16'h0001;
		end
		// Master clock switching sequencer.
		case (s_reg.sw)
			CGS_SW_IDLE: begin
				// Reprogramming the active PLL falls back to slow clock.
				if (s_reg.src == CGS_SRC_PLLA && !s_reg.lock) begin
					s_next.src  = CGS_SRC_SLOW;
					s_next.mrdy = 1'b0;
					s_next.sw   = CGS_SW_PLL;
				end
			end
			CGS_SW_WAIT: begin
				// Old clock stays selected until the count ends.
				if (s_reg.stick) begin
					if (s_reg.swcnt == 8'h00) begin
						s_next.src  = s_reg.mck[1:0];
						s_next.div  = s_reg.mck[6:4];
						s_next.mrdy = 1'b1;
						s_next.sw   = CGS_SW_IDLE;
					end else begin
						s_next.swcnt = s_reg.swcnt - 8'h01;
					end
				end
			end
			CGS_SW_PLL: begin
				if (s_reg.lock) begin
					s_next.src  = s_reg.mck[1:0];
					s_next.mrdy = 1'b1;
					s_next.sw   = CGS_SW_IDLE;
				end
			end
			default: s_next.sw = CGS_SW_IDLE;
		endcase
		// Applied after the sequencer so a switch ending now cannot lose it.
		if (mck_wr) begin
			s_next.mrdy = 1'b0;
			s_next.sw   = CGS_SW_WAIT;
			s_next.swcnt = (hwdata[6:4] != 3'b000)
				? 8'(`CGS_CLOCK_DIVIDE_SELECT_EXTRA) : 8'h04;
		end
		// Programmable ready follows enable after one slow tick.
		if (s_reg.stick) begin
			s_next.pck_rdy = s_reg.pck_on;
		end
		s_next.pck_rdy = s_next.pck_rdy & s_next.pck_on;
		s_next.pll_on = s_next.pll[26:16] != 11'h000;
		s_next.irq = |(sr_val & s_reg.imr);
	end

	// Single state register.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg      <= '0;
			s_reg.osc  <= `CGS_OSC_RESET;
			s_reg.pll  <= `CGS_PLL_RESET;
			s_reg.mck  <= `CGS_MCLK_RESET;
			s_reg.src  <= CGS_SRC_MAIN;
			s_reg.mrdy <= 1'b1;
			s_reg.sw   <= CGS_SW_IDLE;
			s_reg.fwin <= 5'h1F; // First tick wraps it, so windows are full.
		end else begin
			s_reg <= s_next;
		end
	end

	assign hrdata    = s_reg.rdata;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign mclk_src  = s_reg.src;
	assign mclk_div  = s_reg.div;
	assign pck_en    = s_reg.pck_on;
	assign per_en    = s_reg.per;
	assign pll_a_on  = s_reg.pll_on;
	assign irq       = s_reg.irq;

	property p_wp_block;
		@(posedge hclk) disable iff (!hresetn)
		(wr && s_reg.write_protect_enable && s_reg.dadr == `CGS_PER_CLK_ENABLE)
			|=> $stable(s_reg.per) && s_reg.protect_violation_flag;
	endproperty
	a_wp_block: assert property (p_wp_block) else $error("wp leak");
	property p_wp_clear;
		@(posedge hclk) disable iff (!hresetn)
		(hsel && hready && htrans[1] && !hwrite
			&& haddr[11:0] == `CGS_WP_STATE
			&& !(wr && s_reg.write_protect_enable && is_protected(s_reg.dadr)))
			|=> !s_reg.protect_violation_flag;
	endproperty
	a_wp_clear: assert property (p_wp_clear) else $error("wp clear");
	property p_mrdy_drop;
		@(posedge hclk) disable iff (!hresetn)
		(wr && s_reg.dadr == `CGS_MCLK_CONFIG && !s_reg.write_protect_enable) |=> !s_reg.mrdy;
	endproperty
	a_mrdy_drop: assert property (p_mrdy_drop) else $error("mrdy");
	property p_lock_clear;
		@(posedge hclk) disable iff (!hresetn)
		(pll_load && pll_key(hwdata) != pll_key(s_reg.pll)) |=> !s_reg.lock;
	endproperty
	a_lock_clear: assert property (p_lock_clear) else $error("lock");
	property p_fall_slow;
		@(posedge hclk) disable iff (!hresetn)
		(s_reg.sw == CGS_SW_IDLE && s_reg.src == CGS_SRC_PLLA && !s_reg.lock)
			|=> s_reg.src == CGS_SRC_SLOW && !s_reg.mrdy;
	endproperty
	a_fall_slow: assert property (p_fall_slow) else $error("fall");
	property p_irq;
		@(posedge hclk) disable iff (!hresetn)
		(|(sr_val & s_reg.imr)) |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq");
	property p_pck_rdy;
		@(posedge hclk) disable iff (!hresetn)
		s_reg.pck_rdy != 3'b000 |-> (s_reg.pck_rdy & ~s_reg.pck_on) == 3'b000;
	endproperty
	a_pck_rdy: assert property (p_pck_rdy) else $error("pck");
	property p_lock_gate;
		@(posedge hclk) disable iff (!hresetn)
		$rose(s_reg.lock) |-> s_reg.pll[7:0] != 8'h00; 
	endproperty
	a_lock_gate: assert property (p_lock_gate) else $error("div");
	property p_osc;
		@(posedge hclk) disable iff (!hresetn)
		$rose(s_reg.osc_rdy) |-> $past(osc_done);
	endproperty
	a_osc: assert property (p_osc) else $error("osc");
	c_mck: cover property (@(posedge hclk) $rose(s_reg.mrdy));
	c_lock: cover property (@(posedge hclk) $rose(s_reg.lock));
	c_wp: cover property (@(posedge hclk) $rose(s_reg.protect_violation_flag));
endmodule

// >>> cgs_defines.svh
`ifndef CGS_DEFINES_SVH
`define CGS_DEFINES_SVH
// Register byte offsets.
`define CGS_SYS_CLK_ENABLE   12'h000
`define CGS_SYS_CLK_DISABLE  12'h004
`define CGS_SYS_CLK_STATE    12'h008
`define CGS_PER_CLK_ENABLE   12'h010
`define CGS_PER_CLK_DISABLE  12'h014
`define CGS_PER_CLK_STATE    12'h018
`define CGS_USB_PLL_CONFIG   12'h01C
`define CGS_OSC_CONFIG       12'h020
`define CGS_FREQ_MEASURE     12'h024
`define CGS_PLL_A_CONFIG     12'h028
`define CGS_MCLK_CONFIG      12'h030
`define CGS_PROG_CLK0        12'h040
`define CGS_PROG_CLK1        12'h044
`define CGS_PROG_CLK2        12'h048
`define CGS_INT_ENABLE       12'h060
`define CGS_INT_DISABLE      12'h064
`define CGS_CLK_STATUS       12'h068
`define CGS_INT_MASK         12'h06C
`define CGS_FAST_MODE        12'h070
`define CGS_FAST_POLARITY    12'h074
`define CGS_WP_MODE          12'h0E4
`define CGS_WP_STATE         12'h0E8
// Field positions and reset values.
`define CGS_OSC_EN_BIT       0
`define CGS_OSC_ST_LSB       8
`define CGS_OSC_RESET        32'h0000_0001
`define CGS_PLL_DIV_LSB      0
`define CGS_PLL_CNT_LSB      8
`define CGS_PLL_MUL_LSB      16
`define CGS_PLL_RESET        32'h0000_3F00
`define CGS_MCLK_RESET       32'h0000_0001
`define CGS_FREQ_RDY_BIT     16
`define CGS_PCK_LSB          8
// Status register bit positions.
`define CGS_ST_OSC_BIT       0
`define CGS_ST_LOCK_BIT      1
`define CGS_ST_MRDY_BIT      3
`define CGS_ST_PRDY_LSB      8
// Timing counts and the peripheral mask.
`define CGS_OSC_MULT         8
`define CGS_FREQ_WINDOW      16
`define CGS_CLOCK_DIVIDE_SELECT_EXTRA       64
`define CGS_SLOW_DIV         16'h0BEB
`define CGS_PER_MASK         32'h0001_FFFC
`endif

// >>> cgs_pkg.sv
package cgs_pkg;
	typedef enum logic [1:0] {
		CGS_SRC_SLOW = 2'b00,
		CGS_SRC_MAIN = 2'b01,
		CGS_SRC_PLLA = 2'b10,
		CGS_SRC_UPLL = 2'b11
	} cgs_src_e;
	typedef enum logic [1:0] {
		CGS_SW_IDLE = 2'b00,
		CGS_SW_WAIT = 2'b01,
		CGS_SW_PLL  = 2'b10
	} cgs_sw_e;
endpackage

// >>> cgs_counter.sv
`timescale 1ns/10ps
// Down counter that raises done after load value ticks of enable.
module cgs_counter (
	input  wire logic        hclk,    // System clock.
	input  wire logic        hresetn, // Asynchronous reset, low.
	input  wire logic        load,    // Restart the count.
	input  wire logic [15:0] value,   // Ticks to count.
	input  wire logic        tick,    // Count enable.
	output logic             done     // Count elapsed, level.
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        run;
		logic        done;
	} cgs_cnt_s;
	cgs_cnt_s c_reg;
	cgs_cnt_s c_next;
	// Load wins over tick so a restart always begins from the full value.
	always_comb begin
		c_next = c_reg;
		if (load) begin
			c_next.cnt  = value;
			c_next.run  = 1'b1;
			c_next.done = 1'b0;
		end else if (c_reg.run && tick) begin
			if (c_reg.cnt <= 16'h0001) begin
				c_next.run  = 1'b0;
				c_next.done = 1'b1;
			end
			c_next.cnt = c_reg.cnt - 16'h0001;
		end
	end
	// Single state register.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			c_reg <= '0;
		end else begin
			c_reg <= c_next;
		end
	end
	assign done = c_reg.done;
endmodule

// >>> test_clock_generator_sequencing.sv
`timescale 1ns/10ps
`include "cgs_defines.svh"
module test_clock_generator_sequencing;
	localparam int SLOW  = 3052;
	localparam int LIMIT = 95000;
	logic        hclk = 1'b0;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hready;
	logic        main_tick = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [1:0]  mclk_src;
	logic [2:0]  mclk_div;
	logic [2:0]  pck_en;
	logic [31:0] per_en;
	logic        pll_a_on;
	logic        irq;
	int          err_count = 0;
	int          total_checks = 0;
	int          cyc = 0;
	logic [31:0] v;
	logic [31:0] m;
	logic [31:0] exp_per;
	int          t;

	cgs_top DUT (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.main_tick (main_tick),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.mclk_src  (mclk_src),
		.mclk_div  (mclk_div),
		.pck_en    (pck_en),
		.per_en    (per_en),
		.pll_a_on  (pll_a_on),
		.irq       (irq)
	);

	always #5 hclk = ~hclk;

	// The only slave's ready is the bus ready.
	assign hready = hreadyout;

	// One main tick every fourth cycle makes the expected frequency count exact.
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		main_tick <= (cyc[1:0] == 2'b00);
		if (cyc == LIMIT) begin
			err_count++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] e,
			input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, e, g);
		end
	endtask

	// Single word transfer; the request holds until hready is seen high.
	task automatic bus(input logic wr, input logic [11:0] a,
			input logic [31:0] wd, output logic [31:0] rd_v);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {20'h0, a};
		hwrite <= wr;
		hsize <= 3'b010;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd_v = hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		bus(1'b1, a, d, dummy);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		bus(1'b0, a, 32'h0, d);
	endtask

	// Polls until all mask bits are set or maxc cycles pass; the caller judges the time taken.
	task automatic wait_bits(input logic [11:0] a, input logic [31:0] msk,
			input int maxc, output int took);
		logic [31:0] r;
		int t0;
		t0 = cyc;
		rd(a, r);
		while ((r & msk) !== msk && cyc - t0 < maxc) rd(a, r);
		took = cyc - t0;
	endtask

	task automatic wait_irq(input logic val);
		int n;
		for (n = 0; n < 4 && irq !== val; n++) @(posedge hclk);
	endtask

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		void'($urandom(76520));
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// Reset values and unmapped space.
		rd(`CGS_OSC_CONFIG, v);
		check("osc cfg", `CGS_OSC_RESET, v);
		rd(`CGS_PLL_A_CONFIG, v);
		check("pll cfg", `CGS_PLL_RESET, v);
		rd(`CGS_MCLK_CONFIG, v);
		check("mclk cfg", `CGS_MCLK_RESET, v);
		check("mclk src", 32'h1, {30'h0, mclk_src});
		rd(`CGS_CLK_STATUS, v);
		check("status rst", 32'h8, v & 32'h708);
		check("pck_en rst", 32'h0, {29'h0, pck_en});
		check("per_en rst", 32'h0, per_en);
		check("okay", 32'h0, {31'h0, hresp});
		wr(12'h02C, 32'hFFFF_FFFF);
		rd(12'h02C, v);
		check("unmapped", 32'h0, v);
		$display("test reset done");
		// Peripheral gates with random masks.
		exp_per = 32'h0;
		repeat (4) begin
			m = $urandom;
			wr(`CGS_PER_CLK_ENABLE, m);
			exp_per = exp_per | (m & `CGS_PER_MASK);
			@(posedge hclk);
			check("per_en on", exp_per, per_en);
			m = $urandom;
			wr(`CGS_PER_CLK_DISABLE, m);
			exp_per = exp_per & ~m;
			rd(`CGS_PER_CLK_STATE, v);
			check("per state", exp_per, v);
		end
		$display("test peripheral done");
		// Every source and prescaler code while outputs are off.
		for (int s = 0; s < 4; s++) begin
			for (int p = 0; p < 7; p++) begin
				m = {27'h0, p[2:0], s[1:0]};
				wr(12'h040 + 12'((s + p) % 3) * 12'h4, m);
				rd(12'h040 + 12'((s + p) % 3) * 12'h4, v);
				check("pck cfg", m, v & 32'h1F);
			end
		end
		wr(`CGS_SYS_CLK_ENABLE, 32'h700);
		@(posedge hclk);
		check("pck_en on", 32'h7, {29'h0, pck_en});
		wait_bits(`CGS_CLK_STATUS, 32'h700, 4 * SLOW, t);
		check("pck ready", 32'h1, {31'h0, t < 4 * SLOW});
		m = {29'h0, 3'($urandom)};
		wr(`CGS_SYS_CLK_DISABLE, m << 8);
		rd(`CGS_SYS_CLK_STATE, v);
		check("pck state", {29'h0, ~m[2:0]}, (v >> 8) & 32'h7);
		$display("test programmable done");
		// Interrupt follows the master ready flag only while unmasked.
		wr(`CGS_INT_ENABLE, 32'h8);
		wait_irq(1'b1);
		check("irq on", 32'h1, {31'h0, irq});
		rd(`CGS_INT_MASK, v);
		check("irq mask", 32'h8, v & 32'h8);
		wr(`CGS_INT_DISABLE, 32'h8);
		wait_irq(1'b0);
		check("irq off", 32'h0, {31'h0, irq});
		$display("test interrupt done");
		// Protected writes are dropped and reported; reading clears the flag.
		wr(`CGS_WP_MODE, 32'h1);
		wr(`CGS_PER_CLK_ENABLE, `CGS_PER_MASK);
		@(posedge hclk);
		check("per_en prot", exp_per, per_en);
		wr(`CGS_PLL_A_CONFIG, 32'h0001_0201);
		rd(`CGS_PLL_A_CONFIG, v);
		check("pll prot", `CGS_PLL_RESET, v);
		rd(`CGS_WP_STATE, v);
		check("wp state", 32'h0A01, v & 32'hFF01);
		rd(`CGS_WP_STATE, v);
		check("wp clear", 32'h0, v & 32'h1);
		wr(`CGS_WP_MODE, 32'h0);
		$display("test protection done");
		// Lock after the programmed delay; reprogramming drops the lock.
		wr(`CGS_PLL_A_CONFIG, 32'h0007_0201);
		rd(`CGS_CLK_STATUS, v);
		check("lock low", 32'h0, v & 32'h2);
		check("pll on", 32'h1, {31'h0, pll_a_on});
		wait_bits(`CGS_CLK_STATUS, 32'h2, 4 * SLOW, t);
		check("lock time", 32'h1, {31'h0, t >= SLOW && t < 3 * SLOW});
		wr(`CGS_PLL_A_CONFIG, 32'h0008_0201);
		rd(`CGS_CLK_STATUS, v);
		check("relock", 32'h0, v & 32'h2);
		wr(`CGS_PLL_A_CONFIG, 32'h07FF_0201);
		rd(`CGS_PLL_A_CONFIG, v);
		check("mul max", 32'h07FF_0201, v & 32'h07FF_3FFF);
		wr(`CGS_PLL_A_CONFIG, 32'h0000_0201);
		@(posedge hclk);
		check("pll off", 32'h0, {31'h0, pll_a_on});
		$display("test pll done");
		// Oscillator start-up of eight slow ticks per unit.
		wr(`CGS_OSC_CONFIG, 32'h0);
		wr(`CGS_OSC_CONFIG, 32'h0101);
		wait_bits(`CGS_CLK_STATUS, 32'h1, 10 * SLOW, t);
		check("osc time", 32'h1, {31'h0, t >= 7 * SLOW && t <= 9 * SLOW});
		$display("test oscillator done");
		// Sixteen slow ticks with one main tick in every four cycles.
		wait_bits(`CGS_FREQ_MEASURE, 32'h1_0000, 20 * SLOW, t);
		rd(`CGS_FREQ_MEASURE, v);
		check("freq count", 32'h1, {31'h0, v[15:0] >= 15 * SLOW / 4
			&& v[15:0] <= 17 * SLOW / 4});
		$display("test frequency done");
		// Source first, then prescaler; ready drops on each change.
		wr(`CGS_MCLK_CONFIG, 32'h0);
		rd(`CGS_CLK_STATUS, v);
		check("mrdy drop", 32'h0, v & 32'h8);
		wait_bits(`CGS_CLK_STATUS, 32'h8, 6 * SLOW, t);
		check("mrdy time", 32'h1, {31'h0, t >= 3 * SLOW && t < 6 * SLOW});
		check("mclk slow", 32'h0, {30'h0, mclk_src});
		check("mclk div", 32'h0, {29'h0, mclk_div});
		wr(`CGS_MCLK_CONFIG, 32'h10);
		rd(`CGS_CLK_STATUS, v);
		check("mrdy clock_divide_select", 32'h0, v & 32'h8);
		$display("test master done");
		results();
	end
endmodule
